/* File: design/rbs_map.svh */
// Timing, carrier and frame constants of the RFID base station link.
`ifndef RBS_MAP_SVH
`define RBS_MAP_SVH
`define RBS_CLK_MHZ 40
`define RBS_T_SLEEP_US 100000
`define RBS_T_INIT_US 2050
`define RBS_T_DIAG_US 2120
`define RBS_T_READ_US 3000
`define RBS_T_RETRY_US 2050
`define RBS_T_WDLY_US 79
`define RBS_T_SCI_US 64
`define RBS_T_STOP_US 128
`define RBS_T_READY_US 1
`define RBS_T_MCW_US 128
`define RBS_T_SYNC_US 64
`define RBS_T_SYNCL_US 32
`define RBS_T_HSTOP_US 200
`define RBS_T_HINIT_US 2200
`define RBS_DIV_DEF 7'h77
`define RBS_DIV_MIN 7'h72
`define RBS_DIV_MAX 7'h7C
`define RBS_DEAD 7'h0C
`define RBS_MULT_HI 4'h4
`define RBS_MULT_LO 4'h8
`define RBS_MCW_LAST 3'h6
`endif

/* File: design/rbs_pkg.sv */
// Types shared by both ends of the RFID base station link.
package rbs_pkg;

	typedef enum logic [2:0] {
		DS_INIT, DS_IDLE, DS_CHARGE, DS_READ, DS_WRITE, DS_SLEEP
	} rbs_dev_st_t;

	typedef enum logic [2:0] {
		HS_GUARD, HS_IDLE, HS_MCW, HS_CHARGE, HS_LISTEN, HS_CLK_L,
		HS_CLK_H, HS_STOP
	} rbs_host_st_t;

	typedef struct packed {
		rbs_dev_st_t st;
		logic [16:0] tmr;
		logic [16:0] rcnt;
		logic [21:0] slp;
		logic [12:0] lowc;
		logic [16:0] rtry;
		logic trip;
		logic [11:0] wcnt;
		logic wlvl;
		logic ctl_q;
		logic rx_q;
		logic breq_q;
		logic wsync;
		logic [6:0] ph;
		logic ga;
		logic gb;
		logic [3:0] mult;
		logic diag_pend;
		logic rd_go;
		logic sc_busy;
		logic sc_sync;
		logic sc_out;
		logic [7:0] sc_sh;
		logic [3:0] sc_bit;
		logic [11:0] sc_cnt;
	} rbs_dev_state_t;

	typedef struct packed {
		rbs_host_st_t st;
		logic [5:0] pre;
		logic [15:0] tus;
		logic [15:0] chg;
		logic drv_low;
		logic [2:0] mbit;
		logic [6:0] word;
		logic sio_q;
		logic rx_act;
		logic [6:0] rx_cnt;
		logic [3:0] rx_bit;
		logic [7:0] rx_sh;
		logic rx_v;
		logic [7:0] rx_b;
	} rbs_host_state_t;

endpackage : rbs_pkg

/* File: design/rbs_link_if.sv */
// Two-wire link between the base station and its microcontroller.
`timescale 1ns/1ps
interface rbs_link_if;
	logic host_control_input;
	logic serial_data_output;
	modport dev (input host_control_input, output serial_data_output);
	modport host (output host_control_input, input serial_data_output);
endinterface : rbs_link_if

/* File: design/rbs_device.sv */
// Base station control, carrier gating and serial output logic.
`timescale 1ns/1ps
`include "rbs_map.svh"

// Contract
// - Sleep after control held high 100 ms.
// - Control low leaves Sleep at once.
// - Supply drop forces Idle state.
// - Oscillator stopped while in Sleep.
// - PLL multiplies by 4 or 8.
// - Equal gate widths, 12-cycle dead time.
// - First write activation synced at 180 degrees.
// - Bridge drives only in charge or write.
// - Short to ground switches bridge off quickly.
// - Bridge retried 2.05 ms after short.
// - Idle reached 2.05 ms after oscillator start.
// - Diagnosis byte 2.12 ms after leaving Idle.
// - Data sent 3 ms after charge end.
// - Write bridge follows inverted control after 79 us.
// - Host sends mode bits of 128 us.
// - Asynchronous serial bit lasts 64 us.
// - Sync low of 128 us means stop.
// - Host sync clock 4-100 us periods.
// - Sync data ready 1 us after high.
// - Gate duty cycle about 40 percent.
// - LSB first, high start, low stop, inverted.
// - Carrier divider default 119, range 114-124.
module rbs_device
	import rbs_pkg::*;
#(
	parameter int SLEEP_CYC = `RBS_T_SLEEP_US * `RBS_CLK_MHZ,
	parameter int INIT_CYC = `RBS_T_INIT_US * `RBS_CLK_MHZ,
	parameter int DIAG_CYC = `RBS_T_DIAG_US * `RBS_CLK_MHZ,
	parameter int READ_CYC = `RBS_T_READ_US * `RBS_CLK_MHZ,
	parameter int RETRY_CYC = `RBS_T_RETRY_US * `RBS_CLK_MHZ,
	parameter int STOP_CYC = `RBS_T_STOP_US * `RBS_CLK_MHZ
)
(
	input logic clk_i,
	input logic sys_rst_i,
	rbs_link_if.dev lk,
	input logic supply_low_i,
	input logic factor_sel_i,
	input logic write_mode_i,
	input logic sync_mode_i,
	input logic [6:0] carrier_div_i,
	input logic short_a_i,
	input logic short_b_i,
	input logic rx_sig_i,
	input logic [7:0] diag_byte_i,
	input logic data_valid_i,
	input logic [7:0] data_byte_i,
	input logic rx_done_i,
	output logic data_ready_o,
	output logic osc_run_o,
	output logic [3:0] pll_mult_o,
	output logic idle_o,
	output logic fault_o,
	output logic gate_a_n_o,
	output logic gate_b_n_o,
	output logic antenna_output_a_o,
	output logic antenna_output_b_o
);

	localparam logic [11:0] WDLY_CYC = 12'(`RBS_T_WDLY_US * `RBS_CLK_MHZ);
	localparam logic [11:0] SCI_CYC = 12'(`RBS_T_SCI_US * `RBS_CLK_MHZ);
	localparam logic [11:0] RDY_CYC = 12'(`RBS_T_READY_US * `RBS_CLK_MHZ);

	rbs_dev_state_t s;
	rbs_dev_state_t n;
	logic ctl;
	logic ctl_fall;
	logic ctl_rise;
	logic rd_phase;
	logic breq;
	logic on;
	logic act;
	logic [6:0] div;
	logic [6:0] half;
	logic [6:0] wid;
	logic [7:0] ld_byte;
	logic ld;

	assign ctl = lk.host_control_input;
	assign ctl_fall = s.ctl_q & ~ctl;
	assign ctl_rise = ~s.ctl_q & ctl;
	assign rd_phase = (s.st == DS_READ) || (s.st == DS_WRITE);
	assign data_ready_o = rd_phase & s.rd_go & ~s.sc_busy & ~s.diag_pend;

	// ****************************************************************
	// Carrier geometry
	// ****************************************************************
	always_comb
	begin
		div = `RBS_DIV_DEF;
		if (carrier_div_i >= `RBS_DIV_MIN && carrier_div_i <= `RBS_DIV_MAX)
			div = carrier_div_i;
		half = {1'b0, div[6:1]};
		wid = half - `RBS_DEAD;
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		n = s;
		ld = 1'b0;
		ld_byte = data_byte_i;
		n.ctl_q = ctl;
		n.rx_q = rx_sig_i;
		n.mult = factor_sel_i ? `RBS_MULT_HI : `RBS_MULT_LO;
		if (s.tmr != '1)
			n.tmr = s.tmr + 17'h1;
		// Sleep watch counts only while the control line stays high.
		if (!ctl)
			n.slp = '0;
		else if (s.st != DS_SLEEP)
			n.slp = s.slp + 22'h1;
		n.lowc = ctl ? '0 : (s.lowc == 13'(STOP_CYC) ? s.lowc : s.lowc + 13'h1);
		if (ctl != s.ctl_q)
			n.rcnt = '0;
		else if (s.rcnt != 17'(READ_CYC))
			n.rcnt = s.rcnt + 17'h1;

		case (s.st)
			DS_SLEEP:
				if (!ctl)
				begin
					n.st = DS_INIT;
					n.tmr = '0;
				end
			DS_INIT:
				if (s.tmr == 17'(INIT_CYC))
					n.st = DS_IDLE;
			DS_IDLE:
				if (!ctl)
				begin
					n.st = DS_CHARGE;
					n.tmr = '0;
					n.diag_pend = 1'b1;
					n.rd_go = 1'b0;
				end
			DS_CHARGE:
				if (ctl)
					n.st = write_mode_i ? DS_WRITE : DS_READ;
			DS_READ, DS_WRITE:
			begin
				if (ctl && s.rcnt == 17'(READ_CYC))
					n.rd_go = 1'b1;
				if (rx_done_i)
					n.st = DS_IDLE;
				if (s.sc_sync && s.rd_go && s.lowc == 13'(STOP_CYC))
					n.st = DS_IDLE;
			end
			default:
				n.st = DS_IDLE;
		endcase
		if (ctl && s.slp == 22'(SLEEP_CYC - 1))
			n.st = DS_SLEEP;
		if (supply_low_i)
			n.st = DS_IDLE;

		// Write mode: the bridge level trails the inverted control line.
		if (s.st != DS_WRITE)
		begin
			n.wlvl = 1'b0;
			n.wcnt = '0;
		end
		else if (ctl != s.ctl_q)
			n.wcnt = WDLY_CYC;
		else if (s.wcnt != '0)
		begin
			n.wcnt = s.wcnt - 12'h1;
			if (s.wcnt == 12'h1)
				n.wlvl = ~s.ctl_q;
		end

		breq = (s.st == DS_CHARGE) || (s.st == DS_WRITE && s.wlvl);
		on = breq & ~s.trip;
		n.breq_q = breq;

		// Short protection with timed retry.
		if (s.trip)
		begin
			n.rtry = s.rtry + 17'h1;
			if (s.rtry == 17'(RETRY_CYC - 1))
				n.trip = 1'b0;
		end
		else if (on && (short_a_i || short_b_i))
		begin
			n.trip = 1'b1;
			n.rtry = '0;
		end

		// Carrier phase and gate pulses.
		if (s.st == DS_WRITE && breq && !s.breq_q)
			n.wsync = 1'b1;
		if (!breq)
			n.wsync = 1'b0;
		if (!on)
			n.ph = '0;
		else if (s.wsync)
		begin
			if (rx_sig_i && !s.rx_q)
			begin
				n.wsync = 1'b0;
				n.ph = half;
			end
		end
		else
			n.ph = (s.ph == div - 7'h1) ? '0 : s.ph + 7'h1;
		act = on & ~s.wsync & ~(short_a_i | short_b_i);
		n.ga = act && n.ph < wid;
		n.gb = act && n.ph >= half && n.ph < half + wid;

		// ************************************************************
		// Serial output
		// ************************************************************
		if (!s.sc_busy && s.diag_pend && s.tmr >= 17'(DIAG_CYC))
		begin
			ld = 1'b1;
			ld_byte = diag_byte_i;
			n.diag_pend = 1'b0;
		end
		else if (data_valid_i && data_ready_o)
			ld = 1'b1;
		if (ld)
		begin
			n.sc_busy = 1'b1;
			n.sc_sync = sync_mode_i;
			n.sc_sh = ~ld_byte;
			n.sc_out = 1'b1;
			n.sc_bit = '0;
			n.sc_cnt = '0;
		end
		else if (s.sc_busy && !s.sc_sync)
		begin
			n.sc_cnt = s.sc_cnt + 12'h1;
			if (s.sc_cnt == SCI_CYC - 12'h1)
			begin
				n.sc_cnt = '0;
				n.sc_bit = s.sc_bit + 4'h1;
				if (s.sc_bit < 4'h8)
				begin
					n.sc_out = s.sc_sh[0];
					n.sc_sh = {1'b0, s.sc_sh[7:1]};
				end
				else if (s.sc_bit == 4'h8)
					n.sc_out = 1'b0;
				else
					n.sc_busy = 1'b0;
			end
		end
		else if (s.sc_busy)
		begin
			if (s.sc_cnt != RDY_CYC)
				n.sc_cnt = s.sc_cnt + 12'h1;
			else if (ctl_fall && s.sc_bit < 4'h8)
			begin
				n.sc_out = s.sc_sh[0];
				n.sc_sh = {1'b0, s.sc_sh[7:1]};
				n.sc_bit = s.sc_bit + 4'h1;
			end
			else if (ctl_rise && s.sc_bit == 4'h8)
			begin
				n.sc_out = 1'b0;
				n.sc_busy = 1'b0;
			end
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			s <= '0;
		else
			s <= n;
	end

	assign osc_run_o = s.st != DS_SLEEP;
	assign pll_mult_o = s.mult;
	assign idle_o = s.st == DS_IDLE;
	assign fault_o = s.trip;
	assign gate_a_n_o = ~s.ga;
	assign gate_b_n_o = ~s.gb;
	assign antenna_output_a_o = s.ga;
	assign antenna_output_b_o = s.gb;
	assign lk.serial_data_output = s.sc_out;

endmodule : rbs_device

/* File: design/rbs_host.sv */
// Microcontroller end: drives the control line and reads serial data.
`timescale 1ns/1ps
`include "rbs_map.svh"

module rbs_host
	import rbs_pkg::*;
#(
	parameter int GUARD_US = `RBS_T_HINIT_US
)
(
	input logic clk_i,
	input logic sys_rst_i,
	rbs_link_if.host lk,
	input logic cmd_valid_i,
	input logic cmd_mcw_i,
	input logic [6:0] mode_word_i,
	input logic [15:0] charge_us_i,
	input logic sync_i,
	input logic stop_i,
	output logic cmd_ready_o,
	output logic rx_valid_o,
	output logic [7:0] rx_byte_o
);

	localparam logic [5:0] PRE_LAST = 6'(`RBS_CLK_MHZ - 1);
	localparam logic [6:0] RX_SAMPLE = 7'(`RBS_T_SCI_US * 3 / 2 - 1);
	localparam logic [6:0] RX_HALF = 7'(`RBS_T_SCI_US / 2);

	rbs_host_state_t s;
	rbs_host_state_t n;
	logic tick;
	logic ser;

	assign ser = lk.serial_data_output;
	assign tick = s.pre == PRE_LAST;

	always_comb
	begin
		n = s;
		n.rx_v = 1'b0;
		n.sio_q = ser;
		n.pre = tick ? '0 : s.pre + 6'h1;
		if (tick)
			n.tus = s.tus + 16'h1;

		case (s.st)
			HS_GUARD:
				if (s.tus == 16'(GUARD_US))
					n.st = HS_IDLE;
			HS_IDLE:
				if (cmd_valid_i)
				begin
					n.tus = '0;
					n.chg = charge_us_i;
					n.word = mode_word_i;
					n.mbit = '0;
					n.st = cmd_mcw_i ? HS_MCW : HS_CHARGE;
					n.drv_low = cmd_mcw_i ? ~mode_word_i[0] : 1'b1;
				end
			HS_MCW:
				if (tick && s.tus == 16'(`RBS_T_MCW_US - 1))
				begin
					n.tus = '0;
					n.mbit = s.mbit + 3'h1;
					n.drv_low = ~s.word[n.mbit];
					if (s.mbit == `RBS_MCW_LAST)
					begin
						n.st = HS_CHARGE;
						n.drv_low = 1'b1;
					end
				end
			HS_CHARGE:
				if (tick && s.tus == s.chg)
				begin
					n.st = HS_LISTEN;
					n.drv_low = 1'b0;
					n.rx_act = 1'b0;
				end
			HS_LISTEN:
				if (stop_i)
				begin
					n.st = HS_STOP;
					n.drv_low = 1'b1;
					n.tus = '0;
				end
				else if (sync_i && ser && !s.sio_q)
				begin
					n.st = HS_CLK_L;
					n.drv_low = 1'b1;
					n.tus = '0;
					n.rx_bit = '0;
				end
			HS_CLK_L:
				if (tick && s.tus == 16'(`RBS_T_SYNCL_US - 1))
				begin
					n.st = HS_CLK_H;
					n.drv_low = 1'b0;
					n.tus = '0;
				end
			HS_CLK_H:
				if (tick && s.tus == 16'(`RBS_T_SYNC_US - `RBS_T_SYNCL_US - 1))
				begin
					n.rx_sh = {~ser, s.rx_sh[7:1]};
					n.rx_bit = s.rx_bit + 4'h1;
					n.tus = '0;
					n.st = HS_CLK_L;
					n.drv_low = 1'b1;
					if (s.rx_bit == 4'h7)
					begin
						n.rx_v = 1'b1;
						n.rx_b = {~ser, s.rx_sh[7:1]};
						n.st = HS_LISTEN;
						n.drv_low = 1'b0;
					end
				end
			HS_STOP:
				if (tick && s.tus == 16'(`RBS_T_HSTOP_US - 1))
				begin
					n.st = HS_GUARD;
					n.drv_low = 1'b0;
					n.tus = '0;
				end
			default:
				n.st = HS_GUARD;
		endcase

		// Asynchronous receiver samples mid-bit after a high start bit.
		if (s.st == HS_LISTEN && !sync_i)
		begin
			if (!s.rx_act && ser && !s.sio_q)
			begin
				n.rx_act = 1'b1;
				n.rx_cnt = '0;
				n.rx_bit = '0;
			end
			else if (s.rx_act && tick)
			begin
				n.rx_cnt = s.rx_cnt + 7'h1;
				if (s.rx_cnt == RX_SAMPLE)
				begin
					n.rx_cnt = RX_HALF;
					n.rx_sh = {~ser, s.rx_sh[7:1]};
					n.rx_bit = s.rx_bit + 4'h1;
					if (s.rx_bit == 4'h7)
					begin
						n.rx_v = 1'b1;
						n.rx_b = {~ser, s.rx_sh[7:1]};
						n.rx_act = 1'b0;
					end
				end
			end
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			s <= '0;
		else
			s <= n;
	end

	assign lk.host_control_input = ~s.drv_low;
	assign cmd_ready_o = s.st == HS_IDLE;
	assign rx_valid_o = s.rx_v;
	assign rx_byte_o = s.rx_b;

endmodule : rbs_host

/* File: tb/rbs_chk.sv */
// Concurrent checks on the link wire, the antenna bridge outputs, the oscillator, the PLL factor and the supply drop.
`timescale 1ns/1ps
module rbs_chk
#(
	parameter int RETRY_CYC = 300,
	parameter int SLEEP_CYC = 2000
)
(
	input logic clk_i,
	input logic sys_rst_i,
	input logic host_control_input,
	input logic serial_data_output,
	input logic supply_low_i,
	input logic factor_sel_i,
	input logic short_a_i,
	input logic osc_run_o,
	input logic [3:0] pll_mult_o,
	input logic idle_o,
	input logic fault_o,
	input logic gate_a_n_o,
	input logic gate_b_n_o,
	input logic antenna_output_a_o,
	input logic antenna_output_b_o
);
	logic [16:0] fault_len;
	logic [21:0] high_len;

	// Run lengths of the fault flag and of a high control line.
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			fault_len <= 17'h00000;
			high_len <= 22'h000000;
		end
		else
		begin
			fault_len <= fault_o ? fault_len + 17'h00001 : 17'h00000;
			high_len <= host_control_input ? high_len + 22'h000001 : 22'h000000;
		end
	end

	// ********************************************************
	// Properties
	// ********************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_b_held;
		gate_b_n_o[*8] ##1 gate_b_n_o[*4];
	endsequence
	sequence s_start_high;
		serial_data_output[*8] ##1 serial_data_output[*8];
	endsequence

	property p_gap;
		$rose(gate_a_n_o) |-> s_b_held;
	endproperty
	a_gap: assert property (p_gap) else $error("dead time short");
	property p_start_len;
		$rose(serial_data_output) |-> s_start_high;
	endproperty
	a_start_len: assert property (p_start_len) else $error("bit early");
	property p_idle_gnd;
		idle_o |-> !antenna_output_a_o && !antenna_output_b_o;
	endproperty
	a_idle_gnd: assert property (p_idle_gnd) else $error("bridge on");
	property p_short_off;
		short_a_i && antenna_output_a_o |=> fault_o && gate_a_n_o && gate_b_n_o;
	endproperty
	a_short_off: assert property (p_short_off) else $error("no trip");
	property p_retry;
		$fell(fault_o) |-> fault_len inside {[RETRY_CYC-1:RETRY_CYC+1]};
	endproperty
	a_retry: assert property (p_retry) else $error("retry delay");
	property p_pll;
		osc_run_o |=> pll_mult_o == ($past(factor_sel_i) ? 4'h4 : 4'h8);
	endproperty
	a_pll: assert property (p_pll) else $error("pll factor");
	property p_sleep;
		$fell(osc_run_o) |-> high_len inside {[SLEEP_CYC-2:SLEEP_CYC+2]};
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep time");
	property p_wake;
		!host_control_input |-> ##[0:2] osc_run_o;
	endproperty
	a_wake: assert property (p_wake) else $error("still asleep");
	property p_supply;
		supply_low_i |=> idle_o;
	endproperty
	a_supply: assert property (p_supply) else $error("not idle");
endmodule : rbs_chk

/* File: tb/rbs_tb.sv */
// Self-checking run of the host and base station ends over the link.
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin fails++; \
	$display("mismatch %s exp %0h got %0h", n, e, s); end end
module rbs_tb;
	localparam int SLP = 60000;
	localparam int RTY = 300;
	logic clk_i = 1'b0, sys_rst_i = 1'b1, dev_rst = 1'b1;
	logic supply_low_i = 1'b0, factor_sel_i = 1'b1, write_mode_i = 1'b0;
	logic sync_mode_i = 1'b0, short_a_i = 1'b0, short_b_i = 1'b0;
	logic rx_sig_i = 1'b0, data_valid_i = 1'b0, rx_done_i = 1'b0;
	logic cmd_valid_i = 1'b0, cmd_mcw_i = 1'b0, sync_i = 1'b0, stop_i = 1'b0;
	logic [6:0] carrier_div_i = 7'h77, mode_word_i = 7'h00;
	logic [7:0] diag_byte_i = 8'h00, data_byte_i = 8'h00;
	logic [15:0] charge_us_i = 16'h000A;
	logic data_ready_o, osc_run_o, idle_o, fault_o, gate_a_n_o, gate_b_n_o;
	logic antenna_output_a_o, antenna_output_b_o, cmd_ready_o, rx_valid_o;
	logic [3:0] pll_mult_o;
	logic [7:0] rx_byte_o, got, want;
	logic [11:0] cyc = 12'h000;
	int fails = 0, n_checks = 0, seed = 32'h369b;
	int la = 0, lb = 0, wa = 0, wb = 0, k = 0, j = 0;
	rbs_link_if lk ();

	rbs_device #(.SLEEP_CYC(SLP), .INIT_CYC(500), .DIAG_CYC(800),
		.READ_CYC(600), .RETRY_CYC(RTY), .STOP_CYC(200)) u_rbs_device (
		.clk_i, .sys_rst_i(dev_rst), .lk(lk.dev), .supply_low_i,
		.factor_sel_i, .write_mode_i, .sync_mode_i, .carrier_div_i, .short_a_i,
		.short_b_i, .rx_sig_i, .diag_byte_i, .data_valid_i, .data_byte_i,
		.rx_done_i, .data_ready_o, .osc_run_o, .pll_mult_o, .idle_o, .fault_o,
		.gate_a_n_o, .gate_b_n_o, .antenna_output_a_o, .antenna_output_b_o);
	rbs_host #(.GUARD_US(100)) u_rbs_host (.clk_i, .sys_rst_i, .lk(lk.host),
		.cmd_valid_i, .cmd_mcw_i, .mode_word_i, .charge_us_i, .sync_i, .stop_i,
		.cmd_ready_o,
		.rx_valid_o, .rx_byte_o);
	rbs_chk #(.RETRY_CYC(RTY), .SLEEP_CYC(SLP)) u_rbs_chk (.clk_i,
		.sys_rst_i(dev_rst), .host_control_input(lk.host_control_input),
		.serial_data_output(lk.serial_data_output), .supply_low_i,
		.factor_sel_i, .short_a_i, .osc_run_o, .pll_mult_o, .idle_o, .fault_o,
		.gate_a_n_o, .gate_b_n_o, .antenna_output_a_o, .antenna_output_b_o);

	always #12.5 clk_i = ~clk_i;

	always @(posedge clk_i)
	begin
		cyc <= cyc + 12'h001;
		factor_sel_i <= cyc[6];
		rx_sig_i <= cyc[3];
	end

	// Low pulse widths of both gates and the last byte the host took.
	always @(negedge clk_i)
	begin
		if (gate_a_n_o === 1'b0) la++;
		else if (la > 0) begin wa = la; la = 0; end
		if (gate_b_n_o === 1'b0) lb++;
		else if (lb > 0) begin wb = lb; lb = 0; end
		if (rx_valid_o === 1'b1) got = rx_byte_o;
	end

	function automatic logic wire_bit(input logic [7:0] d, input int i);
		if (i == 0) return 1'b1;
		if (i == 9) return 1'b0;
		return ~d[i - 1];
	endfunction : wire_bit

	function automatic logic duty_ok(input int w, input logic [6:0] div);
		return (w * 100 >= 38 * div) && (w * 100 <= 42 * div);
	endfunction : duty_ok

	task report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	// ********************************************************
	// Main sequence
	// ********************************************************
	initial
	begin
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (2000) @(posedge clk_i);
		dev_rst <= 1'b0;
		diag_byte_i <= 8'($random(seed));
		data_byte_i <= 8'($random(seed));
		carrier_div_i <= 7'(114 + $unsigned($random(seed)) % 11);
		charge_us_i <= 16'(10 + $unsigned($random(seed)) % 6);
		for (k = 0; k < 3000 && cmd_ready_o !== 1'b1; k++) @(negedge clk_i);
		@(posedge clk_i) cmd_valid_i <= 1'b1;
		@(posedge clk_i) cmd_valid_i <= 1'b0;
		for (k = 0; k < 400 && wb == 0; k++) @(negedge clk_i);
		`CHK("gate width", 1'b1, (wa - wb <= 1) && (wb - wa <= 1))
		`CHK("duty", 1'b1, duty_ok(wa, carrier_div_i))
		for (k = 0; k < 200 && gate_a_n_o !== 1'b1; k++) @(negedge clk_i);
		for (k = 0; k < 200 && gate_a_n_o !== 1'b0; k++) @(negedge clk_i);
		@(posedge clk_i) short_a_i <= 1'b1;
		@(posedge clk_i) short_a_i <= 1'b0;
		@(negedge clk_i);
		`CHK("fault", 1'b1, fault_o)
		`CHK("bridge", 2'b00, {antenna_output_a_o, antenna_output_b_o})
		$display("test bridge done");
		// First the diagnosis byte, then one data byte offered by the bench.
		for (j = 0; j < 2; j++)
		begin
			want = j ? data_byte_i : diag_byte_i;
			if (j == 1)
			begin
				`CHK("data ready", 1'b1, data_ready_o)
				@(posedge clk_i) data_valid_i <= 1'b1;
				@(posedge clk_i) data_valid_i <= 1'b0;
			end
			for (k = 0; k < 2000 && lk.serial_data_output !== 1'b1; k++)
				@(negedge clk_i);
			repeat (1280) @(negedge clk_i);
			for (k = 0; k < 10; k++)
			begin
				`CHK("wire bit", wire_bit(want, k), lk.serial_data_output)
				repeat (2560) @(negedge clk_i);
			end
			`CHK("rx byte", want, got)
		end
		$display("test serial done");
		for (k = 0; k < 40000 && osc_run_o !== 1'b0; k++) @(negedge clk_i);
		`CHK("sleep", 1'b0, osc_run_o)
		@(posedge clk_i) supply_low_i <= 1'b1;
		@(posedge clk_i) supply_low_i <= 1'b0;
		@(negedge clk_i);
		`CHK("idle", 1'b1, idle_o)
		$display("test sleep done");
		report_and_stop();
	end

	initial
	begin
		repeat (90000) @(posedge clk_i);
		fails++;
		report_and_stop();
	end
endmodule : rbs_tb
